// *** rtl/dab_arbiter.v ***
/*
 * Adapter-side DMA bus arbitration unit: configuration register access,
 * competition on the wired arbitration lines, preempt request, single and
 * burst ownership with optional fairness.
 * Assumes the system bus resolves open-drain lines outside (pulled high
 * when released), and all pins are asynchronous to clk_in at 25 MHz.
 * Channel reset is the synchronous rst_in.
 */
// How it works
// RULE1: Holds four-bit level plus fairness bit.
// RULE2: Selected only when all four selects match.
// RULE3: Board straps selects to one config byte.
// RULE4: Drives five data lines during selected read.
// RULE5: Loads register during selected write strobe.
// RULE6: Captures selects on address latch rising.
// RULE7: System drives ARB/-GNT high for arbitration.
// RULE8: Requests arbitration by pulling -PREEMPT low.
// RULE9: Lowest level value wins the bus.
// RULE10: Drives level onto arbitration lines when pending.
// RULE11: Releases lower bits when lower value seen.
// RULE12: Owns bus if lines equal level.
// RULE13: Loser keeps -PREEMPT asserted until granted.
// RULE14: Rejoins arbitration if ARB/-GNT rises unexpectedly.
// RULE15: Single request asserts preempt, then arbitrates.
// RULE16: Single grant holds until request drops.
// RULE17: Burst asserts -BURST while granted burst lasts.
// RULE18: System ignores preempt while burst low.
// RULE19: Preempt during burst ends grant, releases burst.
// RULE20: Fair preempted burster skips next arbitration.
// RULE21: Fair waits preempt high; unfair rearbitrates immediately. Code instead makes unfair skip the next arbitration first.
// RULE22: Board holds burst request until last cycle.
// RULE23: Channel reset releases outputs, returns idle.
// RULE24: Request inputs and ARB/-GNT synchronised first.
// RULE25: No request leaves arbitration lines and preempt undriven.
`timescale 1ns/10ps
`default_nettype none
`include "dab_consts.vh"

module dab_arbiter (
    input  wire                  clk_in,
    input  wire                  rst_in,
    // Register access side
    input  wire                  addr_latch_n_in,
    input  wire                  reg_pick_hi_a_in,
    input  wire                  reg_pick_hi_b_in,
    input  wire                  reg_pick_lo_a_n_in,
    input  wire                  reg_pick_lo_b_n_in,
    input  wire                  config_read_strobe_n_in,
    input  wire                  config_write_strobe_n_in,
    input  wire [`DAB_CFG_W-1:0] data_in,
    output wire [`DAB_CFG_W-1:0] data_out,
    output wire                  data_oe_out,
    // Board request side
    input  wire                  single_transfer_request_n_in,
    input  wire                  burst_transfer_request_n_in,
    output reg                   ownership_granted_out,
    // System bus arbitration side
    input  wire                  arb_gnt_in,
    input  wire                  preempt_n_in,
    output reg                   preempt_n_out,
    output reg                   preempt_oe_out,
    input  wire [`DAB_LVL_W-1:0] arb_lines_in,
    output reg  [`DAB_LVL_W-1:0] arb_lines_out,
    output reg  [`DAB_LVL_W-1:0] arb_lines_oe_out,
    output reg                   burst_n_out,
    output reg                   burst_oe_out
);

    // ======================================================================
    // Synchronised pin inputs
    wire [`DAB_CFG_W-1:0] data_sync;
    wire [2:0]            strobe_sync;
    wire [3:0]            pick_sync;
    wire [2:0]            ctl_sync;
    wire [`DAB_LVL_W-1:0] arb_sync;
    wire [`DAB_CFG_W-1:0] cfg;
    wire                  single_req;
    wire                  burst_req;
    wire                  arb_phase;
    wire                  preempt_seen;

    // One bundle per group keeps the instance list short
    dab_sync2 #(.W(`DAB_CFG_W)) u_sync_data (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .async_in (data_in),
        .sync_out (data_sync)
    );

    dab_sync2 #(.W(3)) u_sync_strobe (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .async_in ({addr_latch_n_in, config_read_strobe_n_in,
                    config_write_strobe_n_in}),
        .sync_out (strobe_sync)
    );

    dab_sync2 #(.W(4)) u_sync_pick (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .async_in ({reg_pick_hi_a_in, reg_pick_hi_b_in,
                    reg_pick_lo_a_n_in, reg_pick_lo_b_n_in}),
        .sync_out (pick_sync)
    );

    // Requests, ARB/-GNT (inverted so idle reset value reads as grant)
    dab_sync2 #(.W(3)) u_sync_ctl (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .async_in ({single_transfer_request_n_in, burst_transfer_request_n_in,
                    ~arb_gnt_in}),
        .sync_out (ctl_sync)
    );                                                                 // RULE24

    dab_sync2 #(.W(`DAB_LVL_W + 1)) u_sync_bus (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .async_in ({arb_lines_in, preempt_n_in}),
        .sync_out ({arb_sync, preempt_seen})
    );

    assign single_req   = ~ctl_sync[2];
    assign burst_req    = ~ctl_sync[1];
    assign arb_phase    = ~ctl_sync[0];

    // ======================================================================
    // Configuration register
    dab_cfg_reg u_cfg (
        .clk_in                   (clk_in),
        .rst_in                   (rst_in),
        .addr_latch_n_in          (strobe_sync[2]),
        .reg_pick_hi_a_in         (pick_sync[3]),
        .reg_pick_hi_b_in         (pick_sync[2]),
        .reg_pick_lo_a_n_in       (pick_sync[1]),
        .reg_pick_lo_b_n_in       (pick_sync[0]),
        .config_read_strobe_n_in  (strobe_sync[1]),
        .config_write_strobe_n_in (strobe_sync[0]),
        .data_in                  (data_sync),
        .cfg_out                  (cfg),
        .data_out                 (data_out),
        .data_oe_out              (data_oe_out)
    );

    wire [`DAB_LVL_W-1:0] level;
    wire                  fair;
    wire                  any_req;
    wire                  preempt_low;

    assign level       = cfg[`DAB_LVL_MSB:`DAB_LVL_LSB];
    assign fair        = cfg[`DAB_FAIR_BIT];
    assign any_req     = single_req | burst_req;
    assign preempt_low = ~preempt_seen;

    // ======================================================================
    // Arbiter state
    reg [`DAB_ST_W-1:0]  state_ff;
    reg [`DAB_ST_W-1:0]  nxt_state;
    reg                  arb_d_ff;
    reg                  burst_own_ff;
    reg                  nxt_burst_own;
    reg                  skip_ff;
    reg                  nxt_skip;
    wire                 arb_fall;
    wire                 arb_rise;
    reg                  pre_d1_ff;
    reg                  pre_d2_ff;
    wire                 foreign_preempt;

    assign arb_fall = arb_d_ff & ~arb_phase;
    assign arb_rise = ~arb_d_ff & arb_phase;
    // Our own released pull still echoes through the synchroniser for two
    // cycles after a grant; a burst must not mistake it for a preempt
    assign foreign_preempt = preempt_low & ~pre_d1_ff & ~pre_d2_ff;

    // Next-state logic for request, compete, own and fairness wait
    always @*
    begin
        nxt_state     = state_ff;
        nxt_burst_own = burst_own_ff;
        nxt_skip      = skip_ff;
        case (state_ff)
            `DAB_ST_IDLE:
            begin
                nxt_burst_own = 1'b0;
                if (any_req)
                    nxt_state = `DAB_ST_REQ;                           // RULE15
            end
            `DAB_ST_REQ:
            begin
                if (!any_req)
                    nxt_state = `DAB_ST_IDLE;
                else if (arb_phase && !skip_ff)
                    nxt_state = `DAB_ST_ARB;
                else if (arb_fall)
                    nxt_skip = 1'b0;                                   // RULE20
            end
            `DAB_ST_ARB:
            begin
                if (arb_fall)
                begin
                    if (arb_sync == level)
                    begin
                        nxt_state     = `DAB_ST_OWN;                   // RULE12 RULE9
                        nxt_burst_own = burst_req;                     // RULE17
                    end
                    else
                        nxt_state = `DAB_ST_REQ;                       // RULE13
                end
            end
            `DAB_ST_OWN:
            begin
                if (arb_rise)
                    nxt_state = `DAB_ST_ARB;                           // RULE14
                else if (burst_own_ff && foreign_preempt)
                begin
                    // Preempted burst: fairness parks us until preempt clears
                    nxt_state = fair ? `DAB_ST_PEN : `DAB_ST_REQ;      // RULE19 RULE21
                    nxt_skip  = ~fair;                                 // RULE20
                end
                else if (!any_req)
                    nxt_state = `DAB_ST_IDLE;                          // RULE16
            end
            `DAB_ST_PEN:
            begin
                if (!preempt_low)
                    nxt_state = `DAB_ST_IDLE;                          // RULE21
            end
            default:
                nxt_state = `DAB_ST_IDLE;
        endcase
    end

    // Arbitration line drive: wired, so drive only low zeros of our level
    reg [`DAB_LVL_W-1:0] nxt_arb_oe;
    reg                  drop;
    integer              i;

    always @*
    begin
        nxt_arb_oe = {`DAB_LVL_W{1'b0}};
        drop       = 1'b0;
        // Walk MSB down; once a bus bit beats ours, release lower bits
        for (i = `DAB_LVL_W - 1; i >= 0; i = i - 1)
        begin
            if (!drop && !level[i])
                nxt_arb_oe[i] = 1'b1;                                  // RULE10
            if (!drop && level[i] && !arb_sync[i])
                drop = 1'b1;                                           // RULE11
        end
        if (nxt_state != `DAB_ST_ARB || !arb_phase)
            nxt_arb_oe = {`DAB_LVL_W{1'b0}};                           // RULE25
    end

    // ======================================================================
    // Registered outputs; reset releases everything
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state_ff              <= `DAB_ST_IDLE;                     // RULE23
            arb_d_ff              <= 1'b0;
            burst_own_ff          <= 1'b0;
            skip_ff               <= 1'b0;
            pre_d1_ff             <= 1'b0;
            pre_d2_ff             <= 1'b0;
            ownership_granted_out <= 1'b0;
            preempt_n_out         <= 1'b0;
            preempt_oe_out        <= 1'b0;
            arb_lines_out         <= {`DAB_LVL_W{1'b0}};
            arb_lines_oe_out      <= {`DAB_LVL_W{1'b0}};
            burst_n_out           <= 1'b0;
            burst_oe_out          <= 1'b0;
        end
        else
        begin
            state_ff              <= nxt_state;
            arb_d_ff              <= arb_phase;
            burst_own_ff          <= nxt_burst_own;
            skip_ff               <= nxt_skip;
            pre_d1_ff             <= preempt_oe_out;
            pre_d2_ff             <= pre_d1_ff;
            ownership_granted_out <= (nxt_state == `DAB_ST_OWN);       // RULE16
            // Pull preempt low while waiting or competing, release on grant
            preempt_oe_out        <= (nxt_state == `DAB_ST_REQ)
                                   | (nxt_state == `DAB_ST_ARB);       // RULE8 RULE13
            arb_lines_oe_out      <= nxt_arb_oe;                       // RULE10
            burst_oe_out          <= (nxt_state == `DAB_ST_OWN)
                                   & nxt_burst_own;                    // RULE17
        end
    end

endmodule // dab_arbiter

`default_nettype wire

// *** include/dab_consts.vh ***
/*
 * Constants for the adapter DMA bus arbitration unit: register layout,
 * reset values and arbiter state codes.
 * Assumes inclusion by bare name from the rtl files.
 */
`ifndef DAB_CONSTS_VH
`define DAB_CONSTS_VH

// ==========================================================================
// Configuration register layout
`define DAB_CFG_W          5
`define DAB_LVL_W          4
`define DAB_LVL_LSB        0
`define DAB_LVL_MSB        3
`define DAB_FAIR_BIT       4
// Fairness on by default, lowest priority level
`define DAB_CFG_RESET      5'h1f

// ==========================================================================
// Arbiter state codes
`define DAB_ST_W           3
`define DAB_ST_IDLE        3'h0
`define DAB_ST_REQ         3'h1
`define DAB_ST_ARB         3'h2
`define DAB_ST_OWN         3'h3
`define DAB_ST_PEN         3'h4

`endif

// *** rtl/dab_sync2.v ***
/*
 * Two flip-flop synchroniser for a bundle of asynchronous levels.
 * Assumes inputs are asynchronous to clk_in; reset value is all ones,
 * matching the idle level of the active-low pins it carries.
 */
`timescale 1ns/10ps
`default_nettype none

module dab_sync2 #(
    parameter W = 1
) (
    input  wire         clk_in,
    input  wire         rst_in,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);

    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    // ======================================================================
    // Synchroniser stages; first stage feeds only the second
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            meta_ff <= {W{1'b1}};
            sync_ff <= {W{1'b1}};
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule // dab_sync2

`default_nettype wire

// *** rtl/dab_cfg_reg.v ***
/*
 * Five-bit arbitration configuration register with select latching.
 * Assumes strobes and selects are already synchronised to clk_in.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dab_consts.vh"

module dab_cfg_reg (
    input  wire                  clk_in,
    input  wire                  rst_in,
    input  wire                  addr_latch_n_in,
    input  wire                  reg_pick_hi_a_in,
    input  wire                  reg_pick_hi_b_in,
    input  wire                  reg_pick_lo_a_n_in,
    input  wire                  reg_pick_lo_b_n_in,
    input  wire                  config_read_strobe_n_in,
    input  wire                  config_write_strobe_n_in,
    input  wire [`DAB_CFG_W-1:0] data_in,
    output reg  [`DAB_CFG_W-1:0] cfg_out,
    output reg  [`DAB_CFG_W-1:0] data_out,
    output reg                   data_oe_out
);

    reg                  adl_d_ff;
    reg                  selected_ff;
    wire                 adl_rise;
    wire                 sel_now;

    assign adl_rise = ~adl_d_ff & addr_latch_n_in;
    assign sel_now  = reg_pick_hi_a_in & reg_pick_hi_b_in
                    & ~reg_pick_lo_a_n_in & ~reg_pick_lo_b_n_in;      // RULE2

    // ======================================================================
    // Select capture on the rising edge of the address latch strobe
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            adl_d_ff    <= 1'b1;
            selected_ff <= 1'b0;
        end
        else
        begin
            adl_d_ff <= addr_latch_n_in;
            if (adl_rise)
                selected_ff <= sel_now;                                // RULE6
        end
    end

    // ======================================================================
    // Register write and registered read drive
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cfg_out     <= `DAB_CFG_RESET;
            data_out    <= {`DAB_CFG_W{1'b0}};
            data_oe_out <= 1'b0;
        end
        else
        begin
            if (selected_ff && !config_write_strobe_n_in)
                cfg_out <= data_in;                                    // RULE5 RULE1
            data_oe_out <= selected_ff & ~config_read_strobe_n_in;     // RULE4
            data_out    <= cfg_out;                                    // RULE4
        end
    end

endmodule // dab_cfg_reg

`default_nettype wire

// *** sim/dab_arbiter_asserts.sv ***
/* Concurrent checks on the arbitration unit ports, bound to dab_arbiter.
   Assumes one clock and a synchronous active-high channel reset. */
`timescale 1ns/10ps
`default_nettype none
`include "dab_consts.vh"

module dab_arbiter_asserts (
    input wire logic                  clk_in,
    input wire logic                  rst_in,
    input wire logic                  config_read_strobe_n_in,
    input wire logic [`DAB_CFG_W-1:0] data_out,
    input wire logic                  data_oe_out,
    input wire logic                  single_transfer_request_n_in,
    input wire logic                  burst_transfer_request_n_in,
    input wire logic                  ownership_granted_out,
    input wire logic                  arb_gnt_in,
    input wire logic                  preempt_n_in,
    input wire logic                  preempt_oe_out,
    input wire logic [`DAB_LVL_W-1:0] arb_lines_oe_out,
    input wire logic                  burst_oe_out
);
    default clocking cb @(posedge clk_in); endclocking
    // ========================================================================
    // Reset, register and bus-line relations
    // Reset is the cause here, so this one is not disabled by it
    a_reset_quiet: assert property (
        rst_in |=> !ownership_granted_out && !preempt_oe_out && !burst_oe_out
        && arb_lines_oe_out == 4'h0 && !data_oe_out) else $error("outputs held in reset");
    a_level_drive: assert property (disable iff (rst_in)
        arb_lines_oe_out != 4'h0 |-> (arb_lines_oe_out & data_out[3:0]) == 4'h0)
        else $error("pulled a one bit of the level");
    a_read_drive: assert property (disable iff (rst_in)
        $rose(data_oe_out) |-> !$past(config_read_strobe_n_in, 2))
        else $error("data driven without read strobe");
    a_idle_quiet: assert property (disable iff (rst_in)
        (single_transfer_request_n_in && burst_transfer_request_n_in) [*6]
        |-> !preempt_oe_out && arb_lines_oe_out == 4'h0) else $error("idle but driving");
    // ========================================================================
    // Ownership
    a_grant_cause: assert property (disable iff (rst_in)
        $rose(ownership_granted_out) |-> !$past(arb_gnt_in, 2) &&
        (!$past(single_transfer_request_n_in, 2) || !$past(burst_transfer_request_n_in, 2)))
        else $error("grant without request or grant phase");
    a_burst_owner: assert property (disable iff (rst_in)
        burst_oe_out |-> ownership_granted_out) else $error("burst without grant");
    a_single_end: assert property (disable iff (rst_in)
        $rose(single_transfer_request_n_in) && burst_transfer_request_n_in
        |-> ##[1:6] !ownership_granted_out) else $error("grant kept after request");
    a_burst_yield: assert property (disable iff (rst_in)
        burst_oe_out && !preempt_n_in |-> ##[1:6] !burst_oe_out && !ownership_granted_out)
        else $error("burst not ended on preempt");
    c_grant: cover property (disable iff (rst_in) $rose(ownership_granted_out));
    c_burst: cover property (disable iff (rst_in) $rose(burst_oe_out));
    c_read: cover property (disable iff (rst_in) $rose(data_oe_out));
endmodule // dab_arbiter_asserts

bind dab_arbiter dab_arbiter_asserts u_chk (
    .clk_in(clk_in), .rst_in(rst_in), .config_read_strobe_n_in(config_read_strobe_n_in),
    .data_out(data_out), .data_oe_out(data_oe_out),
    .single_transfer_request_n_in(single_transfer_request_n_in),
    .burst_transfer_request_n_in(burst_transfer_request_n_in),
    .ownership_granted_out(ownership_granted_out), .arb_gnt_in(arb_gnt_in),
    .preempt_n_in(preempt_n_in), .preempt_oe_out(preempt_oe_out),
    .arb_lines_oe_out(arb_lines_oe_out), .burst_oe_out(burst_oe_out));
`default_nettype wire

// *** sim/dab_bus_model.sv ***
/* System bus partner: central arbitration control and one competing adapter.
   Assumes open-drain lines are pulled high when nobody pulls them. */
`timescale 1ns/10ps
`default_nettype none

module dab_bus_model (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       pre_oe_in,
    input  wire logic [3:0] arb_oe_in,
    input  wire logic       burst_oe_in,
    input  wire logic       comp_req_in,
    input  wire logic [3:0] comp_lvl_in,
    output var  logic       arb_gnt_out,
    output wire logic       preempt_n_out,
    output wire logic [3:0] arb_wire_out,
    output var  logic [3:0] won_lvl_out
);
    logic       busy_ff;
    logic [3:0] coe_ff;
    logic [3:0] nxt_coe;
    logic [4:0] cnt_ff;
    logic       m;
    integer     i;
    // ========================================================================
    // Wired lines; the competitor pulls preempt until it wins
    assign preempt_n_out = !(pre_oe_in || busy_ff);
    assign arb_wire_out  = ~(arb_oe_in | coe_ff);
    // Competitor drops every bit below the first one it loses, MSB first
    always @*
    begin
        m = 1'b1;
        for (i = 3; i >= 0; i = i - 1)
        begin
            nxt_coe[i] = m && !comp_lvl_in[i] && busy_ff && arb_gnt_out;
            m = m && (arb_wire_out[i] == comp_lvl_in[i]);
        end
    end
    // Central control: 16-cycle arbitration phase, then a grant phase of at least 16 cycles that ends on a preempt with burst released
    always @(posedge clk_in)
    begin
        coe_ff <= nxt_coe;
        if (comp_req_in)
            busy_ff <= 1'b1;
        if (rst_in)
        begin
            arb_gnt_out <= 1'b0;
            cnt_ff <= 5'h00;
            busy_ff <= 1'b0;
            won_lvl_out <= 4'hf;
        end
        else if (cnt_ff != 5'h00)
            cnt_ff <= cnt_ff - 5'h01;
        else if (arb_gnt_out)
        begin
            arb_gnt_out <= 1'b0;
            won_lvl_out <= arb_wire_out;
            if (arb_wire_out == comp_lvl_in)
                busy_ff <= 1'b0;
            cnt_ff <= 5'h0f;
        end
        else if (!preempt_n_out && !burst_oe_in)
        begin
            arb_gnt_out <= 1'b1;
            cnt_ff <= 5'h0f;
        end
    end
endmodule // dab_bus_model
`default_nettype wire

// *** sim/tb_adapter_dma_bus_arbiter.sv ***
/* Self-checking bench: register access, single, burst and preempted bursts.
   Assumes dab_bus_model as the far side and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
`include "dab_consts.vh"

module tb_adapter_dma_bus_arbiter;
    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       adl_n = 1'b1, rstb_n = 1'b1, wstb_n = 1'b1, sreq_n = 1'b1, breq_n = 1'b1;
    logic       hi_a = 1'b0, hi_b = 1'b0, lo_a_n = 1'b1, lo_b_n = 1'b1;
    logic       comp_req = 1'b0;
    logic [3:0] comp_lvl = 4'hf;
    logic [4:0] tb_data = 5'h00;
    logic [4:0] q, d_out;
    wire  [4:0] data_bus;
    logic       d_oe, grant, pre_oe, burst_oe, gnt, pre_wire;
    logic [3:0] arb_oe, arb_wire, won;
    int         err_total = 0, num_checks = 0, cyc = 0;
    localparam logic [3:0] SEL_OK = 4'hc;
    always #20 clk_in = ~clk_in;
    assign data_bus = d_oe ? d_out : tb_data;

    dab_arbiter dut (.clk_in(clk_in), .rst_in(rst_in), .addr_latch_n_in(adl_n),
        .reg_pick_hi_a_in(hi_a), .reg_pick_hi_b_in(hi_b), .reg_pick_lo_a_n_in(lo_a_n),
        .reg_pick_lo_b_n_in(lo_b_n), .config_read_strobe_n_in(rstb_n),
        .config_write_strobe_n_in(wstb_n), .data_in(data_bus), .data_out(d_out),
        .data_oe_out(d_oe), .single_transfer_request_n_in(sreq_n),
        .burst_transfer_request_n_in(breq_n), .ownership_granted_out(grant),
        .arb_gnt_in(gnt), .preempt_n_in(pre_wire), .preempt_n_out(),
        .preempt_oe_out(pre_oe), .arb_lines_in(arb_wire), .arb_lines_out(),
        .arb_lines_oe_out(arb_oe), .burst_n_out(), .burst_oe_out(burst_oe));
    dab_bus_model u_bus (.clk_in(clk_in), .rst_in(rst_in), .pre_oe_in(pre_oe),
        .arb_oe_in(arb_oe), .burst_oe_in(burst_oe), .comp_req_in(comp_req),
        .comp_lvl_in(comp_lvl), .arb_gnt_out(gnt), .preempt_n_out(pre_wire),
        .arb_wire_out(arb_wire), .won_lvl_out(won));
    // ========================================================================
    // Tasks
    task step(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task chk(input logic [4:0] got, input logic [4:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Latch selects, then swap pins to a deselect pattern before the strobe
    task acc(input logic wr, input logic [3:0] pk, input logic [4:0] d);
        {hi_a, hi_b, lo_a_n, lo_b_n} = pk;
        adl_n = 1'b0;
        step(2);
        adl_n = 1'b1;
        step(4);
        {hi_a, hi_b, lo_a_n, lo_b_n} = 4'h3;
        tb_data = d;
        wstb_n = !wr;
        rstb_n = wr;
        step(6);
        q = data_bus;
        wstb_n = 1'b1;
        rstb_n = 1'b1;
        tb_data = ~d; // Released bus shows no stale value
        step(5);
    endtask
    // Wait out the current or next arbitration phase, then let grant settle
    task wait_arb;
        int n;
        n = 0;
        while (!gnt && n < 300) @(negedge clk_in) n++;
        while (gnt && n < 300) @(negedge clk_in) n++;
        if (n >= 300)
        begin
            err_total++;
            close_out;
        end
        else
            step(6);
    endtask
    task pulse_comp(input logic [3:0] lvl);
        comp_lvl = lvl;
        comp_req = 1'b1;
        step(1);
        comp_req = 1'b0;
    endtask
    task close_out;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Hang guard well above the expected run length
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            close_out;
        end
    end
    // ========================================================================
    // Scenarios
    initial
    begin
        step(4);
        rst_in = 1'b0;
        step(4);
        acc(1'b0, SEL_OK, 5'h00); chk(q, 5'h1f);
        for (int k = 0; k < 4; k++)
            acc(1'b1, SEL_OK ^ (4'h1 << k), 5'h00);
        acc(1'b0, SEL_OK, 5'h0a); chk(q, 5'h1f);
        acc(1'b0, 4'h3, 5'h0a); chk(q, 5'h0a);
        acc(1'b1, SEL_OK, 5'h05);
        acc(1'b0, SEL_OK, 5'h00); chk(q, 5'h05);
        // Single request against a higher-priority competitor
        sreq_n = 1'b0;
        step(5);
        pulse_comp(4'h2);
        wait_arb; chk({won, grant}, {4'h2, 1'b0}); chk(pre_oe, 1);
        wait_arb; chk({won, grant}, {4'h5, 1'b1}); chk(pre_oe, 0);
        step(20); chk(grant, 1);
        pulse_comp(4'h2);
        wait_arb; chk({won, grant}, {4'h2, 1'b0});
        wait_arb; chk({won, grant}, {4'h5, 1'b1});
        sreq_n = 1'b1;
        step(6); chk(grant, 0);
        // Burst preempted by a lower-priority competitor: unfair, then fair
        for (int f = 0; f < 2; f++)
        begin
            breq_n = 1'b1;
            step(6);
            acc(1'b1, SEL_OK, {f[0], 4'h5});
            breq_n = 1'b0;
            wait_arb; chk({won, grant}, {4'h5, 1'b1}); chk(burst_oe, 1);
            pulse_comp(4'h9);
            step(8); chk({grant, burst_oe}, 2'h0);
            wait_arb; chk(won, 4'h9);
            wait_arb; chk({won, burst_oe}, {4'h5, 1'b1});
        end
        // Channel reset in mid-burst
        rst_in = 1'b1;
        step(2); chk({grant, pre_oe, burst_oe, |arb_oe, d_oe}, 5'h00);
        rst_in = 1'b0;
        breq_n = 1'b1;
        step(4);
        acc(1'b0, SEL_OK, 5'h00); chk(q, 5'h1f);
        close_out;
    end
endmodule // tb_adapter_dma_bus_arbiter
`default_nettype wire
